/* File: include/alc_defines.vh */
`ifndef ALC_DEFINES_VH
`define ALC_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define ALC_OFS_CTRL 4'h0
`define ALC_OFS_CFG_A 4'h1
`define ALC_OFS_CFG_B 4'h2
`define ALC_OFS_MANUAL 4'h3
`define ALC_OFS_STATUS 4'h4

// ----------------------------------------
// control fields
// ----------------------------------------
`define ALC_CTRL_PAIR_A 0
`define ALC_CTRL_PAIR_B 1
`define ALC_CTRL_QUAD 2
`define ALC_CTRL_FATT 3
`define ALC_CTRL_WAIT_LO 4
`define ALC_CTRL_PWR_LO 8

// ----------------------------------------
// reset values
// ----------------------------------------
`define ALC_RST_CTRL 12'h000
`define ALC_RST_CFG 16'hE100
`define ALC_RST_MANUAL 32'h91919191

// ----------------------------------------
// timing
// ----------------------------------------
`define ALC_CLK_HZ 100000000
`define ALC_FS_HZ 48000
`define ALC_SAMPLE_DIV (`ALC_CLK_HZ / `ALC_FS_HZ)
`define ALC_LIMIT_STEPS 5'd16
`define ALC_WAIT_128 11'd128
`define ALC_WAIT_256 11'd256
`define ALC_WAIT_512 11'd512
`define ALC_WAIT_1024 11'd1024

// ----------------------------------------
// gain: 8-bit code plus 16 fraction bits
// ----------------------------------------
`define ALC_FRAC 16
`define ALC_ATT_CLIP 24'h01046D
`define ALC_ATT_MID 24'h002E81
`define ALC_ATT_LOW 24'h001165
`define ALC_REC_0 24'h0002E5
`define ALC_REC_1 24'h000172
`define ALC_REC_2 24'h0000B9
`define ALC_FAST_0 24'h00022F
`define ALC_FAST_1 24'h0002DE
`define ALC_FAST_2 24'h00045E
`define ALC_FAST_3 24'h0008AB
`define ALC_FATT_STEP 24'h0000B9
`define ALC_MUTE_MAX 8'h04

// ----------------------------------------
// levels, 25-bit magnitude, full scale 2^23
// ----------------------------------------
`define ALC_LVL_M2P5 25'h05FFC7F
`define ALC_LVL_M4P1 25'h04FD6BB
`define ALC_LVL_M6P0 25'h04026E6
`define ALC_LVL_M8P5 25'h0301B7E
`define ALC_LVL_M12 25'h02026F5
`define ALC_LVL_M1P16 25'h06FFF4C
`define ALC_LVL_CLIP 25'h0880D23

`endif

/* File: rtl/alc_gain_chan.v */
`timescale 1ns/1ps
`include "alc_defines.vh"

module alc_gain_chan #(
	parameter GW = 24
) (
	// clock and control
	input wire i_clk,
	input wire i_rst_n,
	input wire i_clr,
	input wire i_tick,
	input wire i_en,
	// level flags
	input wire i_over,
	input wire i_band,
	input wire i_mid,
	input wire i_clip,
	// settings
	input wire [1:0] i_wait_sel,
	input wire [2:0] i_rstep_sel,
	input wire [1:0] i_fstep_sel,
	input wire i_fatt,
	input wire [7:0] i_ref,
	input wire [7:0] i_start,
	// state
	output wire [GW-1:0] o_gain,
	output wire [3:0] o_state
);

localparam S_IDLE = 4'b0001;
localparam S_LIMIT = 4'b0010;
localparam S_WAIT = 4'b0100;
localparam S_REC = 4'b1000;
localparam [`ALC_FRAC-1:0] FZ = {`ALC_FRAC{1'b0}};

reg [3:0] state_r, state_nxt;
reg [GW-1:0] gain_r, gain_nxt;
reg [4:0] step_cnt_r, step_cnt_nxt;
reg [10:0] wait_cnt_r, wait_cnt_nxt;
reg [4:0] div_cnt_r, div_cnt_nxt;
reg [3:0] fatt_cnt_r, fatt_cnt_nxt;
reg fast_r, fast_nxt;
reg [GW-1:0] ref_off_r, ref_off_nxt;
reg [10:0] wait_lim;
reg [GW-1:0] att_step, rec_step, rec_sum;
reg [4:0] div_mask;
wire [GW-1:0] ref_full = {i_ref, FZ};
wire [GW-1:0] ref_eff = (ref_off_r < ref_full) ? ref_full - ref_off_r : {GW{1'b0}};
wire [GW-1:0] att_gain = (gain_r > att_step) ? gain_r - att_step : {GW{1'b0}};
wire [3:0] fatt_mask = i_fatt ? 4'hF : 4'h3;
wire rec_due = fast_r | ((div_cnt_r & div_mask) == 5'h00);

assign o_gain = gain_r;
assign o_state = state_r;

// ----------------------------------------
// step tables
// ----------------------------------------
always @* begin
	case (i_wait_sel)
	2'b00: wait_lim = `ALC_WAIT_128;
	2'b01: wait_lim = `ALC_WAIT_256;
	2'b10: wait_lim = `ALC_WAIT_512;
	default: wait_lim = `ALC_WAIT_1024;
	endcase
	if (i_clip)
		att_step = `ALC_ATT_CLIP;
	else if (i_mid)
		att_step = `ALC_ATT_MID;
	else
		att_step = `ALC_ATT_LOW;
	case (i_rstep_sel)
	3'd0: div_mask = 5'h00;
	3'd1: div_mask = 5'h00;
	3'd2: div_mask = 5'h00;
	3'd3: div_mask = 5'h01;
	3'd4: div_mask = 5'h03;
	3'd5: div_mask = 5'h07;
	3'd6: div_mask = 5'h0F;
	default: div_mask = 5'h1F;
	endcase
	if (fast_r) begin
		case (i_fstep_sel)
		2'b00: rec_step = `ALC_FAST_0;
		2'b01: rec_step = `ALC_FAST_1;
		2'b10: rec_step = `ALC_FAST_2;
		default: rec_step = `ALC_FAST_3;
		endcase
	end else begin
		case (i_rstep_sel)
		3'd0: rec_step = `ALC_REC_0;
		3'd1: rec_step = `ALC_REC_1;
		default: rec_step = `ALC_REC_2;
		endcase
	end
	rec_sum = gain_r + rec_step;
end

// ----------------------------------------
// level control sequence
// ----------------------------------------
always @* begin
	state_nxt = state_r;
	gain_nxt = gain_r;
	step_cnt_nxt = step_cnt_r;
	wait_cnt_nxt = wait_cnt_r;
	div_cnt_nxt = div_cnt_r;
	fatt_cnt_nxt = fatt_cnt_r;
	fast_nxt = fast_r;
	ref_off_nxt = ref_off_r;
	if (!i_en || i_clr) begin
		state_nxt = S_IDLE;
		gain_nxt = {i_start, FZ};
		step_cnt_nxt = 5'd0;
		wait_cnt_nxt = 11'd0;
		div_cnt_nxt = 5'd0;
		fatt_cnt_nxt = 4'd0;
		fast_nxt = 1'b0;
		ref_off_nxt = {GW{1'b0}};
	end else if (i_tick) begin
		case (state_r)
		S_IDLE: begin
			state_nxt = S_WAIT;
			wait_cnt_nxt = 11'd0;
		end
		S_LIMIT: begin
			gain_nxt = att_gain;
			if (i_clip)
				fast_nxt = 1'b1;
			if (step_cnt_r == `ALC_LIMIT_STEPS - 5'd1) begin
				state_nxt = S_WAIT;
				wait_cnt_nxt = 11'd0;
			end else begin
				step_cnt_nxt = step_cnt_r + 5'd1;
			end
		end
		S_WAIT, S_REC: begin
			if (i_over) begin
				state_nxt = S_LIMIT;
				gain_nxt = att_gain;
				step_cnt_nxt = 5'd1;
				fast_nxt = i_clip;
				ref_off_nxt = {GW{1'b0}};
			end else if (i_band) begin
				state_nxt = S_WAIT;
				wait_cnt_nxt = 11'd0;
			end else if (state_r == S_WAIT) begin
				wait_cnt_nxt = wait_cnt_r + 11'd1;
				if (wait_cnt_r == wait_lim - 11'd1) begin
					state_nxt = S_REC;
					div_cnt_nxt = 5'd0;
					fatt_cnt_nxt = 4'd0;
				end
			end else begin
				div_cnt_nxt = div_cnt_r + 5'd1;
				if (rec_due && gain_r < ref_eff)
					gain_nxt = (rec_sum > ref_eff) ? ref_eff : rec_sum;
				if (fast_r) begin
					fatt_cnt_nxt = fatt_cnt_r + 4'd1;
					if ((fatt_cnt_r & fatt_mask) == fatt_mask)
						ref_off_nxt = ref_off_r + `ALC_FATT_STEP;
					if (gain_r >= ref_eff) begin
						fast_nxt = 1'b0;
						ref_off_nxt = {GW{1'b0}};
					end
				end
			end
		end
		default: state_nxt = S_IDLE;
		endcase
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		state_r <= S_IDLE;
		gain_r <= {GW{1'b0}};
		step_cnt_r <= 5'd0;
		wait_cnt_r <= 11'd0;
		div_cnt_r <= 5'd0;
		fatt_cnt_r <= 4'd0;
		fast_r <= 1'b0;
		ref_off_r <= {GW{1'b0}};
	end else begin
		state_r <= state_nxt;
		gain_r <= gain_nxt;
		step_cnt_r <= step_cnt_nxt;
		wait_cnt_r <= wait_cnt_nxt;
		div_cnt_r <= div_cnt_nxt;
		fatt_cnt_r <= fatt_cnt_nxt;
		fast_r <= fast_nxt;
		ref_off_r <= ref_off_nxt;
	end
end

endmodule // alc_gain_chan

/* File: rtl/alc_top.v */
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "alc_defines.vh"

// Function
// - pair-linked: either channel over threshold lowers shared gain each sample
// - quad-linked: any of four channels over threshold lowers one common gain
// - linked channels always carry one identical gain value
// - each limiter event takes exactly sixteen per-sample attenuation steps
// - after an event, new overload starts a new event while enabled
// - quad flag overrides pair enables; pair enable picks linked or manual
// - threshold select picks detection level and timer reset band
// - attenuation step grows with output level in three bands
// - recovery starts only after full wait below the reset band
// - wait select gives 128, 256, 512 or 1024 samples
// - recovery raises gain at programmed step and rate, capped at reference
// - recovery step select sets step size and interval
// - level inside reset band clears the recovery wait timer
// - wait timer runs while level sits below the reset band
// - reference code in 0.375 dB steps, lowest codes mean mute
// - fast recovery after impulse noise with selectable step
// - fast recovery lowers reference every 4 or 16 samples
// - quad mode uses pair A settings only
// - threshold and band on equalised level, clip on raw level
// - linked gain starts from manual volume, pair A left in quad
module alc_top #(
	parameter SAMPLE_DIV = `ALC_SAMPLE_DIV,
	parameter MW = 25,
	parameter GW = 24
) (
	// clock and reset
	input wire i_clk,
	input wire i_rst_n,
	input wire i_sync_clr,
	// register port
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	// channel magnitudes, order A left, A right, B left, B right
	input wire [4*MW-1:0] i_eq_mag,
	input wire [4*MW-1:0] i_raw_mag,
	// gain outputs
	output reg [31:0] o_gain_ch,
	output reg [3:0] o_mute,
	output wire o_sample_tick
);

localparam [7:0] MUTE_MAX = `ALC_MUTE_MAX;
localparam [MW-1:0] LVL_M2P5 = `ALC_LVL_M2P5;
localparam [MW-1:0] LVL_M4P1 = `ALC_LVL_M4P1;
localparam [MW-1:0] LVL_M6P0 = `ALC_LVL_M6P0;
localparam [MW-1:0] LVL_M8P5 = `ALC_LVL_M8P5;
localparam [MW-1:0] LVL_M12 = `ALC_LVL_M12;
localparam [MW-1:0] LVL_MID = `ALC_LVL_M1P16;
localparam [MW-1:0] LVL_CLIP = `ALC_LVL_CLIP;
localparam [31:0] DIV_FULL = SAMPLE_DIV - 1;
localparam [11:0] DIV_LAST = DIV_FULL[11:0];

// ----------------------------------------
// sample tick divider
// ----------------------------------------
reg [11:0] div_r;
reg tick_r;

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		div_r <= 12'h000;
		tick_r <= 1'b0;
	end else if (div_r == DIV_LAST) begin
		div_r <= 12'h000;
		tick_r <= 1'b1;
	end else begin
		div_r <= div_r + 12'h001;
		tick_r <= 1'b0;
	end
end

assign o_sample_tick = tick_r;

// ----------------------------------------
// registers
// ----------------------------------------
reg [11:0] ctrl_r;
reg [15:0] cfg_a_r;
reg [15:0] cfg_b_r;
reg [31:0] manual_r;
wire [3:0] state_a, state_b;
wire [GW-1:0] gain_a, gain_b;

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		ctrl_r <= `ALC_RST_CTRL;
		cfg_a_r <= `ALC_RST_CFG;
		cfg_b_r <= `ALC_RST_CFG;
		manual_r <= `ALC_RST_MANUAL;
	end else if (i_wr) begin
		case (i_addr)
		`ALC_OFS_CTRL: ctrl_r <= i_wdata[11:0];
		`ALC_OFS_CFG_A: cfg_a_r <= i_wdata[15:0];
		`ALC_OFS_CFG_B: cfg_b_r <= i_wdata[15:0];
		`ALC_OFS_MANUAL: manual_r <= i_wdata;
		default: ;
		endcase
	end
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_rdata <= 32'h00000000;
	end else if (i_rd) begin
		case (i_addr)
		`ALC_OFS_CTRL: o_rdata <= {20'h00000, ctrl_r};
		`ALC_OFS_CFG_A: o_rdata <= {16'h0000, cfg_a_r};
		`ALC_OFS_CFG_B: o_rdata <= {16'h0000, cfg_b_r};
		`ALC_OFS_MANUAL: o_rdata <= manual_r;
		`ALC_OFS_STATUS: o_rdata <= {8'h00, state_b, state_a,
			gain_b[GW-1:`ALC_FRAC], gain_a[GW-1:`ALC_FRAC]};
		default: o_rdata <= 32'h00000000;
		endcase
	end else begin
		o_rdata <= 32'h00000000;
	end
end

// ----------------------------------------
// mode selection
// ----------------------------------------
wire quad = ctrl_r[`ALC_CTRL_QUAD];
wire en_a = quad | ctrl_r[`ALC_CTRL_PAIR_A];
wire en_b = ~quad & ctrl_r[`ALC_CTRL_PAIR_B];
wire fatt = ctrl_r[`ALC_CTRL_FATT];
wire [1:0] wait_sel = ctrl_r[`ALC_CTRL_WAIT_LO+1:`ALC_CTRL_WAIT_LO];
// pair B threshold follows pair A in quad mode
wire [1:0] thr_b = quad ? cfg_a_r[1:0] : cfg_b_r[1:0];

// ----------------------------------------
// level detection
// ----------------------------------------
wire [3:0] over, band, mid, clip;

genvar gi;
generate
	for (gi = 0; gi < 4; gi = gi + 1) begin : g_det
		wire [MW-1:0] eq = i_eq_mag[gi*MW +: MW];
		wire [MW-1:0] raw = i_raw_mag[gi*MW +: MW];
		wire [1:0] sel = (gi < 2) ? cfg_a_r[1:0] : thr_b;
		reg [MW-1:0] thr, floor;
		always @* begin
			case (sel)
			2'b00: begin
				thr = LVL_M2P5;
				floor = LVL_M4P1;
			end
			2'b01: begin
				thr = LVL_M4P1;
				floor = LVL_M6P0;
			end
			2'b10: begin
				thr = LVL_M6P0;
				floor = LVL_M8P5;
			end
			default: begin
				thr = LVL_M8P5;
				floor = LVL_M12;
			end
			endcase
		end
		assign over[gi] = (eq >= thr) | (raw >= LVL_CLIP);
		assign band[gi] = (eq >= floor) & (eq < thr);
		assign mid[gi] = eq >= LVL_MID;
		assign clip[gi] = raw >= LVL_CLIP;
	end
endgenerate

// pair A engine sees all four channels in quad mode
wire over_a = quad ? |over : |over[1:0];
wire over_b = |over[3:2];
wire band_a = ~over_a & (quad ? |band : |band[1:0]);
wire band_b = ~over_b & |band[3:2];
wire mid_a = quad ? |mid : |mid[1:0];
wire clip_a = quad ? |clip : |clip[1:0];

// ----------------------------------------
// per-pair gain engines
// ----------------------------------------
alc_gain_chan #(
	.GW(GW)
) u_pair_a (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_clr(i_sync_clr),
	.i_tick(tick_r),
	.i_en(en_a),
	.i_over(over_a),
	.i_band(band_a),
	.i_mid(mid_a),
	.i_clip(clip_a),
	.i_wait_sel(wait_sel),
	.i_rstep_sel(cfg_a_r[4:2]),
	.i_fstep_sel(cfg_a_r[6:5]),
	.i_fatt(fatt),
	.i_ref(cfg_a_r[15:8]),
	.i_start(manual_r[7:0]),
	.o_gain(gain_a),
	.o_state(state_a)
);

alc_gain_chan #(
	.GW(GW)
) u_pair_b (
	.i_clk(i_clk),
	.i_rst_n(i_rst_n),
	.i_clr(i_sync_clr),
	.i_tick(tick_r),
	.i_en(en_b),
	.i_over(over_b),
	.i_band(band_b),
	.i_mid(|mid[3:2]),
	.i_clip(|clip[3:2]),
	.i_wait_sel(wait_sel),
	.i_rstep_sel(cfg_b_r[4:2]),
	.i_fstep_sel(cfg_b_r[6:5]),
	.i_fatt(fatt),
	.i_ref(cfg_b_r[15:8]),
	.i_start(manual_r[23:16]),
	.o_gain(gain_b),
	.o_state(state_b)
);

// ----------------------------------------
// gain outputs
// ----------------------------------------
wire [7:0] code_a = gain_a[GW-1:`ALC_FRAC];
wire [7:0] code_b = gain_b[GW-1:`ALC_FRAC];
reg [31:0] gain_nxt;
reg [3:0] mute_nxt;
integer k;

always @* begin
	gain_nxt = manual_r;
	mute_nxt = 4'h0;
	if (en_a)
		gain_nxt[15:0] = {code_a, code_a};
	if (quad)
		gain_nxt[31:16] = {code_a, code_a};
	else if (en_b)
		gain_nxt[31:16] = {code_b, code_b};
	for (k = 0; k < 4; k = k + 1)
		mute_nxt[k] = gain_nxt[k*8 +: 8] <= MUTE_MAX;
end

always @(posedge i_clk or negedge i_rst_n) begin
	if (!i_rst_n) begin
		o_gain_ch <= 32'h00000000;
		o_mute <= 4'hF;
	end else begin
		o_gain_ch <= gain_nxt;
		o_mute <= mute_nxt;
	end
end

endmodule // alc_top

/* File: test/alc_src_model.sv */
`timescale 1ns/1ps

// ----------------------------------------
// converter level stream
// ----------------------------------------
// magnitudes are only held valid in the tick cycle; otherwise inverted
module alc_src_model #(
	parameter int MW = 25
) (
	// sample timing
	input wire i_tick,
	// commanded levels
	input wire [4*MW-1:0] i_eq,
	input wire [4*MW-1:0] i_raw,
	// to the design
	output wire [4*MW-1:0] o_eq,
	output wire [4*MW-1:0] o_raw
);
	assign o_eq = i_tick ? i_eq : ~i_eq;
	assign o_raw = i_tick ? i_raw : ~i_raw;
endmodule // alc_src_model

/* File: test/alc_top_monitor.sv */
`timescale 1ns/1ps
`include "alc_defines.vh"

module alc_top_monitor #(
	parameter int SAMPLE_DIV = 8,
	parameter int MW = 25,
	parameter int GW = 24
) (
	// clock, reset, register port
	input wire i_clk,
	input wire i_rst_n,
	input wire i_sync_clr,
	input wire [3:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	input wire [31:0] o_rdata,
	// levels and gains
	input wire [4*MW-1:0] i_eq_mag,
	input wire [4*MW-1:0] i_raw_mag,
	input wire [31:0] o_gain_ch,
	input wire [3:0] o_mute,
	input wire o_sample_tick
);
	// ----------------------------------------
	// shadow of settings, age since last change
	// ----------------------------------------
	localparam int TP1 = SAMPLE_DIV - 1;
	reg [11:0] ctrl_r;
	reg [7:0] ref_r;
	reg [31:0] man_r;
	reg [1:0] age_r;
	reg tk_r;
	wire [3:0] clip;
	assign clip[0] = i_raw_mag[MW-1:0] >= `ALC_LVL_CLIP;
	assign clip[1] = i_raw_mag[2*MW-1:MW] >= `ALC_LVL_CLIP;
	assign clip[2] = i_raw_mag[3*MW-1:2*MW] >= `ALC_LVL_CLIP;
	assign clip[3] = i_raw_mag[4*MW-1:3*MW] >= `ALC_LVL_CLIP;
	wire link_a = (ctrl_r[0] | ctrl_r[2]) && age_r == 2'h3;
	wire quad = ctrl_r[2] && age_r == 2'h3;
	wire man_b = !ctrl_r[1] && !ctrl_r[2] && age_r == 2'h3;
	wire hit_a = (|clip[1:0]) || (ctrl_r[2] && (|clip[3:2]));
	always @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			ctrl_r <= 12'h000;
			ref_r <= 8'hE1;
			man_r <= 32'h91919191;
			age_r <= 2'h0;
			tk_r <= 1'b0;
		end else if (i_wr || i_sync_clr) begin
			age_r <= 2'h0;
			tk_r <= 1'b0;
			if (i_wr && i_addr == `ALC_OFS_CTRL) ctrl_r <= i_wdata[11:0];
			if (i_wr && i_addr == `ALC_OFS_CFG_A) ref_r <= i_wdata[15:8];
			if (i_wr && i_addr == `ALC_OFS_MANUAL) man_r <= i_wdata;
		end else begin
			if (age_r != 2'h3) age_r <= age_r + 2'h1;
			if (o_sample_tick && age_r == 2'h3) tk_r <= 1'b1;
		end
	end
	// ----------------------------------------
	// properties
	// ----------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rst_n);
	chk_tick_period: assert property (o_sample_tick |=> !o_sample_tick ##TP1 o_sample_tick)
		else $error("sample tick spacing wrong");
	chk_pair_same: assert property (link_a |-> o_gain_ch[7:0] == o_gain_ch[15:8])
		else $error("pair A gains differ");
	chk_quad_same: assert property (quad |-> o_gain_ch[31:16] == {2{o_gain_ch[7:0]}})
		else $error("quad gains differ");
	chk_manual_b: assert property (man_b |-> o_gain_ch[31:16] == man_r[31:16])
		else $error("pair B not on manual volume");
	chk_mute_map: assert property (o_mute == {o_gain_ch[31:24] <= `ALC_MUTE_MAX,
		o_gain_ch[23:16] <= `ALC_MUTE_MAX, o_gain_ch[15:8] <= `ALC_MUTE_MAX,
		o_gain_ch[7:0] <= `ALC_MUTE_MAX})
		else $error("mute flags do not match gain codes");
	chk_clip_step: assert property (o_sample_tick && link_a && tk_r && hit_a
		&& o_gain_ch[7:0] >= 8'h20 |-> ##2 (o_gain_ch[7:0] == $past(o_gain_ch[7:0], 2) - 8'h01
		|| o_gain_ch[7:0] == $past(o_gain_ch[7:0], 2) - 8'h02))
		else $error("clip step not applied");
	chk_rise_cap: assert property (link_a && $past(link_a)
		&& o_gain_ch[7:0] > $past(o_gain_ch[7:0]) |-> o_gain_ch[7:0] <= ref_r)
		else $error("gain raised above reference");
	chk_state_hot: assert property ($past(i_rd) && $past(i_addr) == `ALC_OFS_STATUS
		|-> $onehot(o_rdata[19:16]) && $onehot(o_rdata[23:20]))
		else $error("engine state not one-hot");
	cov_quad_tick: cover property (quad && o_sample_tick);
	cov_clip: cover property (o_sample_tick && link_a && tk_r && hit_a);
	cov_rise: cover property (link_a && o_gain_ch[7:0] > $past(o_gain_ch[7:0]));
endmodule // alc_top_monitor

bind alc_top alc_top_monitor #(.SAMPLE_DIV(SAMPLE_DIV), .MW(MW), .GW(GW)) i_alc_top_monitor (
	.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sync_clr(i_sync_clr), .i_addr(i_addr),
	.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_eq_mag(i_eq_mag),
	.i_raw_mag(i_raw_mag), .o_gain_ch(o_gain_ch), .o_mute(o_mute), .o_sample_tick(o_sample_tick)
);

/* File: test/tb_alc_top.sv */
`timescale 1ns/1ps
`include "alc_defines.vh"

module tb_alc_top;
	localparam int MW = 25;
	reg i_clk = 1'b0;
	reg i_rst_n = 1'b0;
	reg i_sync_clr = 1'b0;
	reg [3:0] i_addr = 4'h0;
	reg [31:0] i_wdata = 32'h0;
	reg i_wr = 1'b0;
	reg i_rd = 1'b0;
	reg [4*MW-1:0] lvl_eq = '0;
	reg [4*MW-1:0] lvl_raw = '0;
	wire [4*MW-1:0] eq_mag;
	wire [4*MW-1:0] raw_mag;
	wire [31:0] o_rdata;
	wire [31:0] o_gain_ch;
	wire [3:0] o_mute;
	wire o_sample_tick;
	integer n_errors = 0;
	integer tests_run = 0;
	integer g, g1, s, n;
	reg [31:0] rv;
	reg [31:0] man;
	reg [24:0] thr [0:3];
	always #5 i_clk = ~i_clk;
	alc_top #(.SAMPLE_DIV(8)) i_alc_top (.i_clk(i_clk), .i_rst_n(i_rst_n),
		.i_sync_clr(i_sync_clr), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
		.o_rdata(o_rdata), .i_eq_mag(eq_mag), .i_raw_mag(raw_mag), .o_gain_ch(o_gain_ch),
		.o_mute(o_mute), .o_sample_tick(o_sample_tick));
	alc_src_model i_alc_src_model (.i_tick(o_sample_tick), .i_eq(lvl_eq), .i_raw(lvl_raw),
		.o_eq(eq_mag), .o_raw(raw_mag));
	// ----------------------------------------
	// bus, tick and check tasks
	// ----------------------------------------
	task results;
		begin
			$display("checks %0d errors %0d", tests_run, n_errors);
			if (n_errors == 0 && tests_run > 0) $display("[ PASS ]");
			else $display("[ FAIL ]");
			$finish;
		end
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] v);
		begin
			tests_run++;
			if (e !== v) begin
				n_errors++;
				$display("Error %s expected %h seen %h", nm, e, v);
			end
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		begin
			@(posedge i_clk);
			i_wr <= 1'b1;
			i_addr <= a;
			i_wdata <= d;
			@(posedge i_clk);
			i_wr <= 1'b0;
		end
	endtask
	task rd(input [3:0] a);
		begin
			@(posedge i_clk);
			i_rd <= 1'b1;
			i_addr <= a;
			@(posedge i_clk);
			i_rd <= 1'b0;
			@(posedge i_clk);
			rv = o_rdata;
		end
	endtask
	task tk(input integer k);
		repeat (k) begin
			@(posedge i_clk);
			while (o_sample_tick !== 1'b1) @(posedge i_clk);
		end
	endtask
	// one sample of the given levels, then silence
	task pulse(input [4*MW-1:0] e, input [4*MW-1:0] r);
		begin
			lvl_eq <= e;
			lvl_raw <= r;
			tk(1);
			lvl_eq <= '0;
			lvl_raw <= '0;
		end
	endtask
	task state_a(input [3:0] e);
		begin
			rd(`ALC_OFS_STATUS);
			chk("state A", {28'h0, e}, {28'h0, rv[19:16]});
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		thr[0] = `ALC_LVL_M2P5;
		thr[1] = `ALC_LVL_M4P1;
		thr[2] = `ALC_LVL_M6P0;
		thr[3] = `ALC_LVL_M8P5;
		n = $urandom(9376);
		repeat (8) @(posedge i_clk);
		i_rst_n <= 1'b1;
		for (n = 0; n < 6; n++) begin
			rd(n[3:0]);
			chk("reset value", (n == 0 || n == 5) ? 32'h0 : n == 3 ? 32'h91919191 :
				n == 4 ? 32'h00119191 : 32'h0000E100, rv);
		end
		man = {8'h04, 8'h05, 8'($urandom_range(241, 5)), 8'hC0};
		wr(`ALC_OFS_MANUAL, man);
		repeat (4) @(posedge i_clk);
		chk("manual gain", man, o_gain_ch);
		chk("mute", 32'h8, {28'h0, o_mute});
		for (s = 0; s < 4; s++) begin
			wr(`ALC_OFS_CTRL, 32'h0);
			wr(`ALC_OFS_CFG_A, {16'h0, 8'hBF, 1'b0, 2'b00, s[2:0], s[1:0]});
			wr(`ALC_OFS_CTRL, {26'h0, s[1:0], 4'h1});
			tk(2);
			pulse({50'h0, thr[s], 25'h0}, '0);
			tk(14);
			state_a(4'h2);
			tk(1);
			state_a(4'h4);
			g = 'hC00000 - 16 * 'h1165;
			chk("pair A gain", {16'h0, {2{g[23:16]}}}, {16'h0, o_gain_ch[15:0]});
			tk(20);
			pulse({75'h0, thr[s] - 25'h1}, '0);
			state_a(4'h4);
			n = 128 << s;
			tk(n - 4);
			state_a(4'h4);
			tk(8);
			state_a(4'h8);
			tk(120);
			chk("gain cap", 32'hBFBF, {16'h0, o_gain_ch[15:0]});
		end
		wr(`ALC_OFS_CTRL, 32'h0);
		wr(`ALC_OFS_CFG_A, 32'h0000E160);
		wr(`ALC_OFS_CFG_B, 32'h0000E103);
		wr(`ALC_OFS_CTRL, 32'h00000F04);
		tk(2);
		pulse({`ALC_LVL_M6P0, 75'h0}, '0);
		state_a(4'h4);
		pulse('0, {25'h0, `ALC_LVL_CLIP, 50'h0});
		tk(15);
		repeat (2) @(posedge i_clk);
		g = 'hC00000 - 'h1046D - 15 * 'h1165;
		chk("quad gain", {4{g[23:16]}}, o_gain_ch);
		tk(140);
		g1 = o_gain_ch[7:0];
		tk(64);
		g = o_gain_ch[7:0] - g1;
		chk("fast rise", 32'h1, {31'h0, g == 2 || g == 3});
		@(posedge i_clk);
		i_sync_clr <= 1'b1;
		@(posedge i_clk);
		i_sync_clr <= 1'b0;
		state_a(4'h1);
		repeat (2) @(posedge i_clk);
		chk("cleared gain", 32'hC0C0C0C0, o_gain_ch);
		results;
	end
	initial begin
		#600000;
		n_errors++;
		results;
	end
endmodule // tb_alc_top
